/* File: src/mbx_exec.v */
`default_nettype none
`include "mbx_map.vh"
module mbx_exec #(
   parameter STACK_DEPTH = 8
) (
   input wire i_clk,
   input wire i_reset_n,
   input wire i_valid,
   input wire [2:0] i_op,
   input wire [9:0] i_imm,
   input wire i_dest,
   output wire o_ready,
   output reg [9:0] o_pc,
   output reg [7:0] o_acc,
   output reg o_zero,
   output reg [7:0] o_reg_wdata,
   output reg [5:0] o_reg_addr,
   output reg o_reg_we,
   output reg [7:0] o_aux_wdata,
   output reg [3:0] o_aux_addr,
   output reg o_aux_we,
   output reg o_flush,
   output reg [9:0] o_stack_top,
   output reg [2:0] o_stack_ptr
);
   ////////////////////////////////////////////////////////////////
   // shared decoding
   function is_op;
      input [2:0] op;
      input [2:0] code;
      begin
         is_op = (op == code);
      end
   endfunction

   // call and jump both redirect the fetch stream
   function is_branch;
      input [2:0] op;
      begin
         is_branch = (op == `MBX_OP_CALL) || (op == `MBX_OP_JUMP);
      end
   endfunction

   // stack pointer advance, wrapping after the deepest level
   function [2:0] wrap_ptr;
      input [2:0] ptr;
      begin
         if ({29'h0, ptr} == STACK_DEPTH - 1) begin
            wrap_ptr = 3'h0;
         end else begin
            wrap_ptr = ptr + 3'h1;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // register file and return stack
   reg [7:0] data_mem [0:63];
   reg [9:0] stack_mem [0:STACK_DEPTH-1];
   reg refetch_r;
   reg refetch_nxt;
   reg [9:0] pc_nxt;
   reg [7:0] acc_nxt;
   reg zero_nxt;
   reg [7:0] reg_wdata_nxt;
   reg [5:0] reg_addr_nxt;
   reg reg_we_nxt;
   reg [7:0] aux_wdata_nxt;
   reg [3:0] aux_addr_nxt;
   reg aux_we_nxt;
   reg flush_nxt;
   reg [9:0] stack_top_nxt;
   reg [2:0] stack_ptr_nxt;
   wire take;
   wire take_call;
   wire mem_we;
   wire [7:0] mem_wdata;
   wire [7:0] rd_val;
   wire [9:0] pc_inc;

   // no instruction is accepted in the refetch slot after a branch
   assign o_ready = ~refetch_r;
   assign take = i_valid & ~refetch_r;
   assign take_call = take & is_op(i_op, `MBX_OP_CALL);
   assign mem_we = take & (is_op(i_op, `MBX_OP_ACC_REG) | (is_op(i_op, `MBX_OP_REG_MOVE) & i_dest));
   assign mem_wdata = is_op(i_op, `MBX_OP_ACC_REG) ? o_acc : rd_val;
   assign rd_val = data_mem[i_imm[5:0]];
   assign pc_inc = o_pc + 10'h001;

   always @(posedge i_clk) begin
      if (take_call) begin
         stack_mem[o_stack_ptr] <= pc_inc;
      end
      if (mem_we) begin
         data_mem[i_imm[5:0]] <= mem_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   // next-state logic
   always @* begin
      pc_nxt = o_pc;
      acc_nxt = o_acc;
      zero_nxt = o_zero;
      reg_wdata_nxt = o_reg_wdata;
      reg_addr_nxt = o_reg_addr;
      reg_we_nxt = 1'b0;
      aux_wdata_nxt = o_aux_wdata;
      aux_addr_nxt = o_aux_addr;
      aux_we_nxt = 1'b0;
      flush_nxt = 1'b0;
      stack_top_nxt = o_stack_top;
      stack_ptr_nxt = o_stack_ptr;
      refetch_nxt = 1'b0;
      if (take) begin
         pc_nxt = pc_inc;
         case (i_op)
            `MBX_OP_AUX_LOAD: begin
               aux_addr_nxt = i_imm[3:0];
               aux_wdata_nxt = o_acc;
               aux_we_nxt = 1'b1;
            end
            `MBX_OP_CALL: begin
               stack_top_nxt = pc_inc;
               stack_ptr_nxt = wrap_ptr(o_stack_ptr);
               pc_nxt = i_imm;
            end
            `MBX_OP_JUMP: begin
               pc_nxt = i_imm;
            end
            `MBX_OP_IMM_ACC: begin
               acc_nxt = i_imm[7:0];
            end
            `MBX_OP_ACC_REG: begin
               reg_addr_nxt = i_imm[5:0];
               reg_wdata_nxt = o_acc;
               reg_we_nxt = 1'b1;
            end
            `MBX_OP_REG_MOVE: begin
               if (i_dest) begin
                  reg_addr_nxt = i_imm[5:0];
                  reg_wdata_nxt = rd_val;
                  reg_we_nxt = 1'b1;
               end else begin
                  acc_nxt = rd_val;
               end
               // the flag follows the moved value for both destinations
               zero_nxt = (rd_val == 8'h00);
            end
            default: begin
            end
         endcase
         // the prefetched word is stale after a redirect
         if (is_branch(i_op)) begin
            flush_nxt = 1'b1;
            refetch_nxt = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // program counter, accumulator and zero flag
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pc <= `MBX_PC_RST;
         o_acc <= `MBX_ACC_RST;
         o_zero <= 1'b0;
      end else begin
         o_pc <= pc_nxt;
         o_acc <= acc_nxt;
         o_zero <= zero_nxt;
      end
   end

   // write echoes towards the register file and the aux page
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_wdata <= 8'h00;
         o_reg_addr <= 6'h00;
         o_reg_we <= 1'b0;
         o_aux_wdata <= 8'h00;
         o_aux_addr <= 4'h0;
         o_aux_we <= 1'b0;
      end else begin
         o_reg_wdata <= reg_wdata_nxt;
         o_reg_addr <= reg_addr_nxt;
         o_reg_we <= reg_we_nxt;
         o_aux_wdata <= aux_wdata_nxt;
         o_aux_addr <= aux_addr_nxt;
         o_aux_we <= aux_we_nxt;
      end
   end

   // refetch slot and return stack state
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_flush <= 1'b0;
         refetch_r <= 1'b0;
         o_stack_top <= 10'h000;
         o_stack_ptr <= `MBX_SP_RST;
      end else begin
         o_flush <= flush_nxt;
         refetch_r <= refetch_nxt;
         o_stack_top <= stack_top_nxt;
         o_stack_ptr <= stack_ptr_nxt;
      end
   end
endmodule // mbx_exec
`default_nettype wire

/* File: src/mbx_map.vh */
`ifndef MBX_MAP_VH
`define MBX_MAP_VH
// operation codes presented on i_op
`define MBX_OP_NONE 3'h0
`define MBX_OP_AUX_LOAD 3'h1
`define MBX_OP_CALL 3'h2
`define MBX_OP_JUMP 3'h3
`define MBX_OP_IMM_ACC 3'h4
`define MBX_OP_ACC_REG 3'h5
`define MBX_OP_REG_MOVE 3'h6
// widths and reset values
`define MBX_PC_W 10
`define MBX_PC_RST 10'h000
`define MBX_ACC_RST 8'h00
`define MBX_SP_RST 3'h0
`endif

/* File: tb/mbx_exec_checker.sv */
`default_nettype none
module mbx_exec_checker(input wire i_clk,i_reset_n,i_valid,i_dest,o_ready,o_zero,o_reg_we,o_aux_we,o_flush,
input wire [2:0] i_op,o_stack_ptr,input wire [9:0] i_imm,o_pc,o_stack_top,
input wire [7:0] o_acc,o_reg_wdata,o_aux_wdata);
default clocking @(posedge i_clk); endclocking
default disable iff (!i_reset_n);
wire t=i_valid&o_ready;
aux_load_a: assert property(t&&i_op==1|=>o_aux_we&&o_aux_wdata==$past(o_acc)) else $error("aux");
call_a: assert property(t&&i_op==2|=>o_stack_top==$past(o_pc)+10'h1&&o_pc==$past(i_imm)) else $error("call");
jump_a: assert property(t&&i_op==3|=>o_pc==$past(i_imm)&&$stable(o_stack_ptr)) else $error("jump");
imm_acc_a: assert property(t&&i_op==4|=>o_acc==$past(i_imm[7:0])&&$stable(o_zero)) else $error("imm");
acc_reg_a: assert property(t&&i_op==5|=>o_reg_we&&o_reg_wdata==$past(o_acc)) else $error("store");
self_move_a: assert property(t&&i_op==6&&i_dest|=>o_reg_we&&$stable(o_acc)) else $error("move");
zero_flag_a: assert property(t&&i_op==6|=>o_zero==(($past(i_dest)?o_reg_wdata:o_acc)==8'h0)) else $error("z");
refetch_a: assert property(t&&i_op[2:1]==1|=>o_flush&&!o_ready ##1 o_ready&&!o_flush) else $error("flush");
endmodule // mbx_exec_checker
bind mbx_exec mbx_exec_checker chk(.*);
`default_nettype wire

/* File: tb/mbx_exec_bench.sv */
`default_nettype none
module mbx_exec_bench;
timeunit 1ns;
timeprecision 1ns;
logic i_clk=0,i_reset_n=0,i_valid=0,i_dest=0,z=0;
logic [2:0] i_op=0;
logic [9:0] i_imm=0,pc=0;
logic [7:0] acc=0,mem[64];
logic [2:0] sp=0;
wire o_ready,o_zero,o_reg_we,o_aux_we,o_flush;
wire [2:0] o_stack_ptr;
wire [9:0] o_pc,o_stack_top;
wire [7:0] o_acc,o_reg_wdata,o_aux_wdata;
wire [5:0] o_reg_addr;
wire [3:0] o_aux_addr;
int bad_count=0,tests_run=0,cyc=0;
mbx_exec DUT(.*);
always #50 i_clk=~i_clk;
always @(posedge i_clk) if(++cyc>2000) begin
   bad_count++;
   finish_test;
end
task chk(input string n,input [9:0] e,s);
   tests_run++;
   if(e!==s) begin
      bad_count++;
      $display("wrong value %s %h %h",n,e,s);
   end
endtask
task run(input [2:0] op,input [9:0] m,input d);
   @(negedge i_clk) {i_valid,i_op,i_imm,i_dest}={1'b1,op,m,d};
   @(negedge i_clk) i_valid=0;
   if(op==2) chk("top",pc+10'h1,o_stack_top);
   if(op==1) chk("aux",acc,o_aux_wdata);
   if(op==5) chk("wd",acc,o_reg_wdata);
   if(op==5) chk("waddr",m[5:0],o_reg_addr);
   if(op==1) chk("aux_addr",m[3:0],o_aux_addr);
   chk("aux_we",op==1,o_aux_we);
   chk("reg_we",op==5||(op==6&&d),o_reg_we);
   if(op==6&&d) chk("self",mem[m[5:0]],o_reg_wdata);
   if(op==2) sp=sp+3'h1;
   chk("sp",sp,o_stack_ptr);
   if(op==3) chk("jump",m,o_pc);
   if(!(op inside {2,3})) chk("ready",1,o_ready);
   if(op==4) acc=m[7:0];
   if(op==5) mem[m[5:0]]=acc;
   if(op==6) z=mem[m[5:0]]==0;
   if(op==6&&!d) acc=mem[m[5:0]];
   pc=op inside {2,3}?m:pc+10'h1;
   chk("pc",pc,o_pc);
   chk("acc",acc,o_acc);
   chk("zero",z,o_zero);
   if(op inside {2,3}) chk("flush",1,o_flush&!o_ready);
endtask
task finish_test;
   $display("mismatches %0d checks %0d",bad_count,tests_run);
   if(bad_count==0&&tests_run>0) $display("All tests passed");
   else $display("Some tests failed");
   $finish;
endtask
initial begin
   void'($urandom(61221));
   repeat(8) @(negedge i_clk);
   i_reset_n=1;
   for(int i=0;i<64;i++) begin
      run(4,$urandom,0);
      run(5,i,0);
   end
   run(4,0,0);
   run(5,63,0);
   run(4,90,0);
   run(6,63,1);
   run(6,63,0);
   run(2,1023,0);
   run(3,0,0);
   run(1,15,0);
   $display("corner tests done");
   repeat(400) run($urandom_range(6,1),$urandom,$urandom);
   $display("random tests done");
   finish_test;
end
endmodule // mbx_exec_bench
`default_nettype wire
